// ---- sbc_ctrl.sv ----
// synchronous pipelined burst cache ram: address, burst, write and output control
module sbc_ctrl
  import sbc_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic                      clk_sys,
  input  wire logic                      rst_b,
  input  wire logic [sbc_pkg::ADDR_W-1:0] addr,
  input  wire logic                      processor_addr_strobe_n,
  input  wire logic                      controller_addr_strobe_n,
  input  wire logic                      burst_advance_n,
  input  wire logic                      burst_order,
  input  wire logic                      chip_select_a_n,
  input  wire logic                      chip_select_b,
  input  wire logic                      chip_select_c_n,
  input  wire logic                      byte_write_enable_n,
  input  wire logic [sbc_pkg::LANES-1:0] byte_lane_select_n,
  input  wire logic                      global_write_n,
  input  wire logic                      output_enable_n,
  input  wire logic                      sleep_request,
  input  wire logic [sbc_pkg::DATA_W-1:0] data_in,
  output logic      [sbc_pkg::DATA_W-1:0] data_out,
  output logic                           data_oe,
  input  wire logic [sbc_pkg::LANES-1:0] parity_io_in,
  output logic      [sbc_pkg::LANES-1:0] parity_io_out,
  output logic                           parity_io_oe,
  output logic                           write_ready
);
  import sbc_pkg::*;

  localparam int UP_W = ADDR_W - BURST_W;

  // beat address of either burst order
  function automatic logic [1:0] beat_addr(input logic order, input logic [1:0] start,
                                           input logic [1:0] beat);
    beat_addr = order ? (start ^ beat) : 2'(start + beat);
  endfunction

  // word layout: lane i is {parity i, data byte i}
  function automatic sbc_word_t pack_word(input logic [DATA_W-1:0] d,
                                          input logic [LANES-1:0] p);
    pack_word = {p[1], d[15:8], p[0], d[7:0]};
  endfunction

  logic [UP_W-1:0]    base;
  logic [1:0]         start;
  logic [1:0]         beat;
  logic               active;
  logic               wr_cycle;
  sbc_word_t          rd_word;
  sbc_word_t          mem [2**ADDR_W];

  // chip selection and strobe qualification
  wire sel        = !chip_select_a_n && chip_select_b && !chip_select_c_n;
  wire awake      = !sleep_request;
  wire p_strobe   = !processor_addr_strobe_n && !chip_select_a_n;
  wire c_strobe   = !controller_addr_strobe_n && !p_strobe;
  wire any_strobe = p_strobe || c_strobe;
  wire p_load     = awake && p_strobe && sel;
  wire c_load     = awake && c_strobe && sel;
  wire load       = p_load || c_load;
  wire advance    = awake && !any_strobe && !burst_advance_n && active;

  wire [1:0] next_beat = load ? BEAT_RST : (advance ? 2'(beat + BEAT_STEP) : beat);
  wire [1:0] next_start = load ? addr[1:0] : start;
  wire [UP_W-1:0] next_base = load ? addr[ADDR_W-1:BURST_W] : base;
  wire next_active = (awake && any_strobe) ? sel : active;

  // address of the access sampled on this edge
  wire sbc_addr_t eff_addr = {next_base, beat_addr(burst_order, next_start, next_beat)};
  wire sbc_addr_t cur_addr = {base, beat_addr(burst_order, start, beat)};

  // write qualification; a processor strobe cycle is never a write
  wire byte_wr   = !byte_write_enable_n && (byte_lane_select_n != LANES_ALL);
  wire glob_wr   = !global_write_n;
  wire wr_hit    = awake && next_active && !p_load && (glob_wr || byte_wr);
  wire [LANES-1:0] wr_lanes = glob_wr ? LANES_ALL : ~byte_lane_select_n;
  wire rd_hit    = awake && next_active && !wr_hit;

  sbc_wr_req_s wr_req;
  sbc_wr_req_s drain_req;
  logic        drain_valid;
  wire         rd_access   = rd_hit && (load || advance);
  // only a cycle that starts or steps a read holds the array port; held cycles
  // let the queue drain, so a run of idle reads never starves a queued write
  wire         drain_ready = !rd_access;

  assign wr_req.addr  = eff_addr;
  assign wr_req.word  = pack_word(data_in, parity_io_in);
  assign wr_req.lanes = wr_lanes;

  // writes queue and retire without external timing; a read to a word still
  // queued sees the old value, so partners must not read back inside the queue time
  sbc_fifo #(
    .W     (REQ_W),
    .DEPTH (DEPTH)
  ) u_wr_fifo (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .in_valid  (wr_hit),
    .in_ready  (write_ready),
    .in_data   (wr_req),
    .out_valid (drain_valid),
    .out_ready (drain_ready),
    .out_data  (drain_req)
  );

  // registered address and burst state, sampled on the rising edge only
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      base <= BASE_RST;
    end else begin
      base <= next_base;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      start <= BEAT_RST;
      beat  <= BEAT_RST;
    end else begin
      start <= next_start;
      beat  <= next_beat;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      active <= 1'b0;
    end else begin
      active <= next_active;
    end
  end

  // write float flag keeps its value through sleep
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_cycle <= 1'b0;
    end else begin
      wr_cycle <= awake ? wr_hit : wr_cycle;
    end
  end

  // self-timed array update, one lane mask per queued entry
  always_ff @(posedge clk_sys) begin
    if (drain_valid && drain_ready) begin
      for (int i = 0; i < LANES; i++) begin
        if (drain_req.lanes[i])
          mem[drain_req.addr][i*LANE_W +: LANE_W] <= drain_req.word[i*LANE_W +: LANE_W];
      end
    end
  end

  // pipelined read: word addressed on this edge shows after it
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_word <= WORD_RST;
    end else if (rd_hit) begin
      rd_word <= mem[eff_addr];
    end
  end

  assign data_out      = {rd_word[16:9], rd_word[7:0]};
  assign parity_io_out = {rd_word[17], rd_word[8]};
  // output enable acts without the clock; writes and deselect force the float
  assign data_oe       = !output_enable_n && active && !wr_cycle && awake;
  assign parity_io_oe  = data_oe;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  addr_capture_a: assert property (load |=> base == $past(addr[ADDR_W-1:BURST_W])
      && start == $past(addr[1:0]) && beat == BEAT_RST)
    else $error("strobe did not capture address");
  strobe_prio_a: assert property (!(p_load && c_load))
    else $error("both strobes acted on");
  csa_gate_a: assert property ((chip_select_a_n && awake) |=> $stable(base) && $stable(start))
    else $error("address moved with first select high");
  burst_step_a: assert property (advance |=> beat == 2'($past(beat) + BEAT_STEP))
    else $error("advance did not step counter");
  burst_wrap_a: assert property (advance ##1 advance ##1 advance ##1 advance
      |=> base == $past(base, 4) && beat == $past(beat, 4))
    else $error("burst counter did not wrap in four beats");
  idle_hold_a: assert property ((awake && !any_strobe && burst_advance_n)
      |=> $stable(beat) && $stable(base) && $stable(start))
    else $error("idle cycle moved burst state");
  order_seq_a: assert property (burst_order |-> cur_addr[1:0] == (start ^ beat))
    else $error("interleaved order wrong");
  linear_seq_a: assert property (!burst_order |-> cur_addr[1:0] == 2'(start + beat))
    else $error("linear order wrong");
  global_all_a: assert property ((wr_hit && glob_wr) |-> wr_req.lanes == LANES_ALL)
    else $error("global write missed a lane");
  write_float_a: assert property (wr_hit |=> !data_oe && !parity_io_oe)
    else $error("outputs driven on write cycle");
  oe_async_a: assert property (output_enable_n |-> !data_oe)
    else $error("driving with output enable high");
  sleep_hold_a: assert property (sleep_request |=> $stable(base) && $stable(beat)
      && $stable(rd_word) && $stable(active))
    else $error("state changed in sleep");

  // strobe qualification and address capture
  ctrl_load_a: assert property ((awake && sel && !controller_addr_strobe_n
      && processor_addr_strobe_n) |=> base == $past(addr[ADDR_W-1:BURST_W])
      && start == $past(addr[1:0]))
    else $error("controller strobe did not load address");
  proc_load_a: assert property ((awake && sel && !processor_addr_strobe_n)
      |=> base == $past(addr[ADDR_W-1:BURST_W]) && start == $past(addr[1:0]))
    else $error("processor strobe did not load address");
  proc_wins_a: assert property ((awake && sel && !processor_addr_strobe_n
      && !controller_addr_strobe_n) |-> !c_load && !wr_hit)
    else $error("controller strobe acted beside processor strobe");
  strobe_start_a: assert property ((awake && sel && any_strobe)
      |=> active)
    else $error("strobe did not start an access");
  select_gate_a: assert property ((!chip_select_b || chip_select_c_n)
      |=> $stable(base) && $stable(start))
    else $error("address captured while deselected");
  deselect_float_a: assert property ((awake && any_strobe && !sel)
      |=> !active && !data_oe)
    else $error("deselect left outputs driven");
  first_beat_a: assert property (load
      |=> cur_addr == $past(addr))
    else $error("first beat not at strobed address");
  write_addr_a: assert property ((c_load && wr_hit)
      |-> wr_req.addr == addr)
    else $error("write queued at wrong address");

  // burst counter
  upper_fixed_a: assert property ((wr_hit && !load)
      |-> wr_req.addr[ADDR_W-1:BURST_W] == base)
    else $error("burst write left its upper address");
  counter_wrap_a: assert property ((advance && beat == 2'h3)
      |=> beat == BEAT_RST)
    else $error("counter did not wrap after fourth beat");
  no_carry_a: assert property (advance
      |=> $stable(base) && $stable(start))
    else $error("counter carried into upper address");
  inter_step_a: assert property ((advance && beat == BEAT_RST && burst_order)
      ##1 burst_order |-> cur_addr[1:0] == (start ^ 2'h1))
    else $error("interleaved second beat wrong");
  linear_step_a: assert property ((advance && beat == BEAT_RST && !burst_order)
      ##1 !burst_order |-> cur_addr[1:0] == 2'(start + 2'h1))
    else $error("linear second beat wrong");
  idle_count_a: assert property ((!active && !load)
      |=> $stable(beat))
    else $error("counter stepped with no access open");

  // write qualification, output drive and sleep
  lane_mask_a: assert property ((wr_hit && global_write_n)
      |-> wr_req.lanes == ~byte_lane_select_n && !byte_write_enable_n)
    else $error("byte write lanes wrong");
  byte_none_a: assert property ((global_write_n && byte_lane_select_n == LANES_ALL)
      |-> !wr_hit)
    else $error("write queued with no lane selected");
  global_load_a: assert property ((c_load && !global_write_n)
      |-> wr_hit && wr_req.lanes == LANES_ALL)
    else $error("global write not queued on all lanes");
  sleep_quiet_a: assert property (sleep_request
      |-> !load && !wr_hit && !data_oe)
    else $error("sleep did not silence the pins");
  idle_float_a: assert property (!active
      |-> !data_oe && !parity_io_oe)
    else $error("outputs driven with no access open");
  read_drive_a: assert property ((rd_hit && load && !output_enable_n)
      ##1 (!output_enable_n && !sleep_request) |-> data_oe)
    else $error("read cycle did not drive outputs");

  proc_burst_c: cover property (p_load ##1 advance ##1 advance ##1 advance);
  ctrl_write_c: cover property (c_load && wr_hit ##1 advance && wr_hit);
  global_write_c: cover property (wr_hit && glob_wr && !byte_write_enable_n);
  fifo_full_c: cover property (!write_ready);
  wrap_beat_c: cover property (advance && beat == 2'h3);
endmodule // sbc_ctrl

// ---- sbc_fifo.sv ----
// parameterised valid/ready fifo holding queued array writes
module sbc_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [W-1:0] store [DEPTH];
  logic [PW:0]  count;
  logic [PW-1:0] rd_ptr;
  logic [PW-1:0] wr_ptr;
  wire           push = in_valid && in_ready;
  wire           pop  = out_valid && out_ready;

  assign in_ready  = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = store[rd_ptr];

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      count  <= '0;
      rd_ptr <= '0;
      wr_ptr <= '0;
    end else begin
      if (push) wr_ptr <= PW'(wr_ptr + 1'b1);
      if (pop) rd_ptr <= PW'(rd_ptr + 1'b1);
      count <= (PW+1)'(count + (PW+1)'(push) - (PW+1)'(pop));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) store[wr_ptr] <= in_data;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  no_overflow_a: assert property (count <= (PW+1)'(DEPTH))
    else $error("fifo count above depth");
  full_blocks_a: assert property (!in_ready
      |=> count == $past(count) - (PW+1)'($past(pop)))
    else $error("fifo accepted while full");
endmodule // sbc_fifo

// ---- sbc_host_model.sv ----
// host side model: processor and cache controller driving the pin bus
module sbc_host_model
  import sbc_pkg::*;
(
  input  wire logic       clk_sys,
  output sbc_pkg::sbc_addr_t addr,
  output logic            processor_addr_strobe_n,
  output logic            controller_addr_strobe_n,
  output logic            burst_advance_n,
  output logic            global_write_n,
  output logic            byte_write_enable_n,
  output logic [1:0]      byte_lane_select_n,
  output logic [15:0]     data_in,
  output logic [1:0]      parity_io_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n} = 3'h7;
    {global_write_n, byte_write_enable_n, byte_lane_select_n} = 4'hf;
    addr = '0;
    {parity_io_in, data_in} = 18'h0;
  end
  // one transfer at an edge, then an idle cycle; released lines flip so stale values never pass
  task automatic drive(input logic [4:0] op, input sbc_addr_t a, input logic [17:0] w,
                       input logic [1:0] ln);
    @(posedge clk_sys);
    {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n} <= op[4:2];
    {global_write_n, byte_write_enable_n} <= op[1:0];
    byte_lane_select_n <= ln;
    addr <= a;
    {parity_io_in, data_in} <= w;
    @(posedge clk_sys);
    {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n} <= 3'h7;
    {global_write_n, byte_write_enable_n, byte_lane_select_n} <= 4'hf;
    addr <= ~a;
    {parity_io_in, data_in} <= ~w;
    #1;
  endtask
endmodule // sbc_host_model

// ---- sbc_pkg.sv ----
// shared constants and carrier types for the burst cache ram control
package sbc_pkg;
  localparam int          ADDR_W      = 18;
  localparam int          DATA_W      = 16;
  localparam int          LANES       = 2;
  localparam int          LANE_W      = 9;
  localparam int          WORD_W      = LANES * LANE_W;
  localparam int          BURST_W     = 2;
  localparam int          FIFO_DEPTH  = 16;
  localparam int          CLK_PERIOD_NS = 40;
  localparam logic [1:0]  BEAT_RST    = 2'h0;
  localparam logic [1:0]  BEAT_STEP   = 2'h1;
  localparam logic [1:0]  LANES_ALL   = 2'h3;
  localparam logic [1:0]  LANES_NONE  = 2'h0;
  localparam logic [15:0] BASE_RST    = 16'h0000;
  localparam logic [17:0] WORD_RST    = 18'h00000;

  typedef logic [ADDR_W-1:0] sbc_addr_t;
  typedef logic [WORD_W-1:0] sbc_word_t;

  typedef struct packed {
    sbc_addr_t        addr;
    sbc_word_t        word;
    logic [LANES-1:0] lanes;
  } sbc_wr_req_s;

  localparam int REQ_W = $bits(sbc_wr_req_s);
endpackage

// ---- sync_burst_cache_sram_ctrl_tb.sv ----
// self-checking bench for the burst cache ram control block
module sync_burst_cache_sram_ctrl_tb
  import sbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic       ord;
    logic [1:0] st;
    logic [7:0] seq;
    logic       prc;
  } sbc_row_s;
  localparam logic [15:0] BASE_HI = 16'h1234;
  logic        clk_sys, rst_b, processor_addr_strobe_n, controller_addr_strobe_n;
  logic        burst_advance_n, global_write_n, byte_write_enable_n, burst_order;
  logic        chip_select_a_n, chip_select_b, chip_select_c_n, sleep_request;
  logic        output_enable_n, data_oe, parity_io_oe, write_ready;
  logic [1:0]  byte_lane_select_n, parity_io_in, parity_io_out;
  logic [15:0] data_in, data_out;
  logic [17:0] e;
  sbc_addr_t   addr, a0, a1, a2;
  int          error_cnt = 0;
  int          checked = 0;
  logic [17:0] mdl [sbc_addr_t];
  // beats of each burst packed two bits apiece, first beat on top
  sbc_row_s    rows [8] = '{'{1, 0, 8'h1b, 1}, '{1, 1, 8'h4e, 0}, '{1, 2, 8'hb1, 1},
    '{1, 3, 8'he4, 0}, '{0, 0, 8'h1b, 0}, '{0, 1, 8'h6c, 1}, '{0, 2, 8'hb1, 0}, '{0, 3, 8'hc6, 1}};

  // small queue so a dropped or stalled drain shows quickly
  sbc_ctrl #(.DEPTH(2)) i_sbc_ctrl (.clk_sys(clk_sys), .rst_b(rst_b), .addr(addr),
    .processor_addr_strobe_n(processor_addr_strobe_n), .burst_advance_n(burst_advance_n),
    .controller_addr_strobe_n(controller_addr_strobe_n), .burst_order(burst_order),
    .chip_select_a_n(chip_select_a_n), .chip_select_b(chip_select_b),
    .chip_select_c_n(chip_select_c_n), .byte_write_enable_n(byte_write_enable_n),
    .byte_lane_select_n(byte_lane_select_n), .global_write_n(global_write_n),
    .output_enable_n(output_enable_n), .sleep_request(sleep_request), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .parity_io_in(parity_io_in),
    .parity_io_out(parity_io_out), .parity_io_oe(parity_io_oe), .write_ready(write_ready));
  sbc_host_model i_sbc_host_model (.clk_sys(clk_sys), .addr(addr),
    .processor_addr_strobe_n(processor_addr_strobe_n), .burst_advance_n(burst_advance_n),
    .controller_addr_strobe_n(controller_addr_strobe_n), .global_write_n(global_write_n),
    .byte_write_enable_n(byte_write_enable_n), .byte_lane_select_n(byte_lane_select_n),
    .data_in(data_in), .parity_io_in(parity_io_in));

  task automatic chk(input string what, input logic [17:0] got, input logic [17:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // order, output enable, sleep, three selects
  task automatic setl(input logic [5:0] v);
    @(posedge clk_sys);
    {burst_order, output_enable_n, sleep_request} <= v[5:3];
    {chip_select_a_n, chip_select_b, chip_select_c_n} <= v[2:0];
    #1;
  endtask
  task automatic rdp(input sbc_addr_t a);
    i_sbc_host_model.drive(5'h0f, a, 18'h0, 2'h3);
    chk("read word", {parity_io_out, data_out}, mdl[a]);
    chk("drive on", {data_oe, parity_io_oe}, 18'h3);
  endtask
  task automatic wrg(input sbc_addr_t a, input logic [17:0] w, input logic [4:0] op);
    i_sbc_host_model.drive(op, a, w, 2'h3);
    chk("write float", {data_oe, parity_io_oe}, 18'h0);
    mdl[a] = w;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    conclude();
  end
  initial begin
    rst_b = 1'b0;
    {burst_order, output_enable_n, sleep_request} = 3'h0;
    {chip_select_a_n, chip_select_b, chip_select_c_n} = 3'h2;
    repeat (20) @(posedge clk_sys);
    #1;
    chk("reset word", {parity_io_out, data_out}, 18'h0);
    chk("reset flags", {data_oe, parity_io_oe, write_ready}, 18'h1);
    @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wrg({BASE_HI, 2'(i)}, 18'h0a500 + 18'(i) * 18'h10001, 5'h15);
    end
    for (int r = 0; r < 8; r++) begin
      setl({rows[r].ord, 5'h02});
      for (int b = 0; b < 5; b++) begin
        i_sbc_host_model.drive(b == 0 ? (rows[r].prc ? 5'h0f : 5'h17) : 5'h1b,
                               {BASE_HI, rows[r].st}, 18'h0, 2'h3);
        e = mdl[{BASE_HI, rows[r].seq[7-2*(b%4) -: 2]}];
        chk("burst beat", {parity_io_out, data_out}, e);
        chk("strobe read", {data_oe, 17'h0}, 18'h20000);
      end
    end
    a0 = {BASE_HI, 2'h0};
    a1 = {BASE_HI, 2'h1};
    a2 = {BASE_HI, 2'h2};
    i_sbc_host_model.drive(5'h16, a0, 18'h3ffff, 2'h2);
    mdl[a0] = {mdl[a0][17], 1'b1, mdl[a0][15:8], 8'hff};
    i_sbc_host_model.drive(5'h17, a0, 18'h0, 2'h1);
    chk("byte lane", {parity_io_out, data_out}, mdl[a0]);
    rdp(a0);
    wrg(a1, 18'h2c3c3, 5'h14);
    i_sbc_host_model.drive(5'h05, a2, 18'h0, 2'h3);
    chk("both strobes", {parity_io_out, data_out}, mdl[a2]);
    rdp(a1);
    rdp(a2);
    setl(6'h06);
    i_sbc_host_model.drive(5'h0f, a0, 18'h0, 2'h3);
    chk("gated strobe", {parity_io_out, data_out}, mdl[a2]);
    setl(6'h02);
    i_sbc_host_model.drive(5'h1b, a0, 18'h0, 2'h3);
    chk("kept burst", {parity_io_out, data_out}, mdl[{BASE_HI, 2'h3}]);
    for (int k = 0; k < 3; k++) begin
      setl(6'h02 ^ (6'h04 >> k));
      i_sbc_host_model.drive(5'h15, a0, 18'h0, 2'h3);
      chk("deselect", {data_oe, parity_io_oe}, 18'h0);
      setl(6'h02);
      rdp(a0);
    end
    setl(6'h12);
    chk("oe high", {data_oe, parity_io_oe}, 18'h0);
    setl(6'h0a);
    i_sbc_host_model.drive(5'h15, a0, 18'h0, 2'h3);
    chk("sleep float", {data_oe, parity_io_oe}, 18'h0);
    setl(6'h02);
    rdp(a0);
    chk("queue room", {17'h0, write_ready}, 18'h1);
    @(posedge clk_sys);
    rst_b <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk("mid reset word", {parity_io_out, data_out}, 18'h0);
    chk("mid reset flags", {data_oe, parity_io_oe, write_ready}, 18'h1);
    @(posedge clk_sys);
    rst_b <= 1'b1;
    rdp(a2);
    conclude();
  end
endmodule // sync_burst_cache_sram_ctrl_tb
